/* rtl/mlfs_pkg.sv */
package mlfs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ   = 100;
  localparam int T_READ_NS = 25000;
  localparam int T_PROG_NS = 200000;
  localparam int READ_CYC  = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYC  = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W     = 24;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_ROW    = 8'h04;
  localparam logic [7:0] A_COL    = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0C;
  localparam logic [7:0] A_DATA   = 8'h10;
  localparam logic [7:0] A_DEFECT = 8'h14;
  localparam logic [7:0] A_ECC_LO = 8'h18;
  localparam logic [7:0] A_ECC_HI = 8'h1C;

  // ---------------------------------------------------------------
  // Flash opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_READ     = 8'h00;
  localparam logic [7:0] OP_READ_GO  = 8'h30;
  localparam logic [7:0] OP_PROG     = 8'h80;
  localparam logic [7:0] OP_PLANE    = 8'h11;
  localparam logic [7:0] OP_PROG_GO  = 8'h10;
  localparam logic [7:0] OP_STAT     = 8'h70;
  localparam logic [7:0] OP_STAT_ENH = 8'h78;

  // ---------------------------------------------------------------
  // Data values and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] MARK16     = 16'h0000;
  localparam logic [7:0]  MARK8      = 8'h00;
  localparam logic [15:0] ERASED16   = 16'hFFFF;
  localparam logic [7:0]  ERASED8    = 8'hFF;
  localparam logic [7:0]  CW_MIN_EXP = 8'h09;
  localparam int          DEF_LUN_LSB = 16;
  localparam int          DEF_EN_BIT  = 31;

  typedef enum logic [1:0] {
    LUN_IDLE = 2'b00,
    LUN_READ = 2'b01,
    LUN_PROG = 2'b10
  } mlfs_lun_e;

  // Endurance as {multiplier, value} with the smallest value
  function automatic logic [15:0] mlfs_norm_endur(input int val, input int mult);
    int v;
    int m;
    v = val;
    m = mult;
    while (v != 0 && v % 10 == 0) begin
      v = v / 10;
      m = m + 1;
    end
    return {m[7:0], v[7:0]};
  endfunction

endpackage

/* rtl/mlfs_top.sv */
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Unchained program start clears idle LUN page registers
// - Read accepted while another LUN programs
// - Ready/busy low whenever any LUN busy
// - Enhanced status disables unaddressed LUN drivers
// - Defect marker at first spare element
// - Good blocks read as all ones
// - ECC info block eight bytes, fixed layout
// - Codeword exponent reported at least nine
// - Endurance value byte smallest, multiplier byte
// - Zero correctability means error-free data
// - Ready/busy is AND of LUN ready bits
// - Enhanced status keeps output page register
// - Row address: page low, block, LUN high
module mlfs_top
  import mlfs_pkg::*;
#(
  parameter int          NUM_LUNS      = 2,
  parameter int          LUN_BITS      = 1,
  parameter int          BLK_BITS      = 10,
  parameter int          PAGE_BITS     = 6,
  parameter int          COL_BITS      = 13,
  parameter int          PAGE_ELEMS    = 2048,
  parameter int          PAGES_PER_BLK = 64,
  parameter bit          BUS16         = 1'b0,
  parameter int          READ_CYCLES   = READ_CYC,
  parameter int          PROG_CYCLES   = PROG_CYC,
  parameter logic [7:0]  ECC_BITS      = 8'h04,
  parameter logic [7:0]  CW_EXP        = 8'h09,
  parameter logic [15:0] MAX_BAD       = 16'h0014,
  parameter int          ENDUR_VAL     = 100,
  parameter int          ENDUR_MULT    = 3
) (
  input  wire logic                CLK_I,
  input  wire logic                RST_I,
  input  wire logic                CYC_I,
  input  wire logic                STB_I,
  input  wire logic                WE_I,
  input  wire logic [7:0]          ADR_I,
  input  wire logic [3:0]          SEL_I,
  input  wire logic [31:0]         DAT_I,
  output logic      [31:0]         DAT_O,
  output logic                     ACK_O,
  output logic                     RB_N_O,
  output logic                     RB_OE_N_O,
  output logic      [NUM_LUNS-1:0] DQ_OE_N_O
);

  localparam int ROW_W = PAGE_BITS + BLK_BITS + LUN_BITS;

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_mux;
  logic [31:0] bmask;
  logic        req;
  logic        wr_go;
  logic        rd_go;

  assign req   = CYC_I & STB_I;
  assign wr_go = req & WE_I & ack_r;
  assign rd_go = req & ~WE_I & ~ack_r;
  assign bmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  assign ACK_O = ack_r;
  assign DAT_O = dat_r;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (rd_go) begin
        dat_r <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address registers and command decode
  // ---------------------------------------------------------------
  logic [31:0] row_r;
  logic [31:0] col_r;
  logic [31:0] def_r;
  logic [7:0]  last_op_r;
  logic        cmd_go;
  logic [7:0]  op;

  assign cmd_go = wr_go & (ADR_I == A_CMD) & SEL_I[0];
  assign op     = DAT_I[7:0];

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      row_r     <= 32'h0000_0000;
      col_r     <= 32'h0000_0000;
      def_r     <= 32'h0000_0000;
      last_op_r <= 8'h00;
    end else begin
      if (wr_go && ADR_I == A_ROW) row_r <= (row_r & ~bmask) | (DAT_I & bmask);
      if (wr_go && ADR_I == A_COL) col_r <= (col_r & ~bmask) | (DAT_I & bmask);
      if (wr_go && ADR_I == A_DEFECT) def_r <= (def_r & ~bmask) | (DAT_I & bmask);
      if (cmd_go) last_op_r <= op;
    end
  end

  logic [PAGE_BITS-1:0] row_page;
  logic [BLK_BITS-1:0]  row_blk;
  logic [LUN_BITS-1:0]  row_lun;

  assign row_page = row_r[PAGE_BITS-1:0];
  assign row_blk  = row_r[PAGE_BITS +: BLK_BITS];
  assign row_lun  = row_r[PAGE_BITS + BLK_BITS +: LUN_BITS];

  // ---------------------------------------------------------------
  // Per-LUN operation state
  // ---------------------------------------------------------------
  mlfs_lun_e            st_r     [NUM_LUNS];
  logic [CNT_W-1:0]     cnt_r    [NUM_LUNS];
  logic [ROW_W-1:0]     ld_row_r [NUM_LUNS];
  logic [NUM_LUNS-1:0]  pv_r;
  logic [NUM_LUNS-1:0]  ready;
  logic [NUM_LUNS-1:0]  rd_hit;
  logic [NUM_LUNS-1:0]  pg_hit;
  logic                 plane_r;
  logic                 start_rd;
  logic                 start_pg;
  logic                 prog_clear;
  logic                 rb_ready;

  assign start_rd   = cmd_go & (op == OP_READ_GO) & ready[row_lun];
  assign start_pg   = cmd_go & (op == OP_PROG_GO) & ready[row_lun];
  assign prog_clear = cmd_go & (op == OP_PROG) & ~plane_r;

  for (genvar g = 0; g < NUM_LUNS; g++) begin : g_lun
    assign ready[g]  = (st_r[g] == LUN_IDLE);
    assign rd_hit[g] = start_rd & (row_lun == LUN_BITS'(g));
    assign pg_hit[g] = start_pg & (row_lun == LUN_BITS'(g));
  end

  assign rb_ready  = &ready;
  assign RB_N_O    = 1'b0;
  assign RB_OE_N_O = rb_ready;

  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < NUM_LUNS; i++) begin
      if (RST_I) begin
        st_r[i]     <= LUN_IDLE;
        cnt_r[i]    <= '0;
        ld_row_r[i] <= '0;
        pv_r[i]     <= 1'b0;
      end else begin
        unique case (st_r[i])
          LUN_IDLE: begin
            if (rd_hit[i]) begin
              st_r[i]     <= LUN_READ;
              cnt_r[i]    <= CNT_W'(READ_CYCLES - 1);
              ld_row_r[i] <= row_r[ROW_W-1:0];
              pv_r[i]     <= 1'b0;
            end else if (pg_hit[i]) begin
              st_r[i]  <= LUN_PROG;
              cnt_r[i] <= CNT_W'(PROG_CYCLES - 1);
              pv_r[i]  <= 1'b0;
            end else if (prog_clear) begin
              pv_r[i] <= 1'b0;
            end
          end
          LUN_READ: begin
            if (cnt_r[i] == '0) begin
              st_r[i] <= LUN_IDLE;
              pv_r[i] <= 1'b1;
            end else begin
              cnt_r[i] <= cnt_r[i] - 1'b1;
            end
          end
          LUN_PROG: begin
            if (cnt_r[i] == '0) begin
              st_r[i] <= LUN_IDLE;
            end else begin
              cnt_r[i] <= cnt_r[i] - 1'b1;
            end
          end
          default: st_r[i] <= LUN_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Selection, output mode and multi-LUN tracking
  // ---------------------------------------------------------------
  logic [LUN_BITS-1:0]  sel_lun_r;
  logic                 out_mode_r;
  logic                 mlun_r;
  logic [NUM_LUNS-1:0]  oe_n_r;
  logic [NUM_LUNS-1:0]  oe_n_nxt;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      plane_r    <= 1'b0;
      sel_lun_r  <= '0;
      out_mode_r <= 1'b0;
      mlun_r     <= 1'b0;
      oe_n_r     <= '1;
    end else begin
      oe_n_r <= oe_n_nxt;
      if (cmd_go && op == OP_PLANE) plane_r <= 1'b1;
      else if (cmd_go && op == OP_PROG_GO) plane_r <= 1'b0;
      if (cmd_go && op == OP_STAT_ENH) begin
        sel_lun_r  <= row_lun;
        out_mode_r <= 1'b0;
        mlun_r     <= 1'b0;
      end else if ((start_rd || start_pg) && !rb_ready) begin
        mlun_r <= 1'b1;
      end
      if (cmd_go && op == OP_STAT) out_mode_r <= 1'b0;
      else if (cmd_go && op == OP_READ) out_mode_r <= 1'b1;
    end
  end

  for (genvar g = 0; g < NUM_LUNS; g++) begin : g_oe
    assign oe_n_nxt[g] = ~(out_mode_r & (sel_lun_r == LUN_BITS'(g)));
  end
  assign DQ_OE_N_O = oe_n_r;

  // ---------------------------------------------------------------
  // Data output from the selected page register
  // ---------------------------------------------------------------
  logic [ROW_W-1:0]     out_row;
  logic [PAGE_BITS-1:0] out_page;
  logic [BLK_BITS-1:0]  out_blk;
  logic                 marker_loc;
  logic                 def_hit;
  logic [15:0]          elem;
  logic [31:0]          data_word;

  assign out_row    = ld_row_r[sel_lun_r];
  assign out_page   = out_row[PAGE_BITS-1:0];
  assign out_blk    = out_row[PAGE_BITS +: BLK_BITS];
  assign marker_loc = (col_r[COL_BITS-1:0] == COL_BITS'(PAGE_ELEMS)) &&
                      (out_page == '0 || out_page == PAGE_BITS'(PAGES_PER_BLK - 1));
  assign def_hit    = def_r[DEF_EN_BIT] && marker_loc &&
                      (def_r[DEF_LUN_LSB +: LUN_BITS] == sel_lun_r) &&
                      (def_r[BLK_BITS-1:0] == out_blk);
  // Stored values come back exact, whatever the correctability
  assign elem = def_hit ? (BUS16 ? MARK16 : {8'h00, MARK8}) :
                          (BUS16 ? ERASED16 : {8'h00, ERASED8});
  assign data_word = (out_mode_r && pv_r[sel_lun_r]) ? {16'h0000, elem} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Extended ECC information and read mux
  // ---------------------------------------------------------------
  localparam logic [15:0] ENDUR = mlfs_norm_endur(ENDUR_VAL, ENDUR_MULT);
  localparam logic [7:0]  CW_FIELD = (CW_EXP < CW_MIN_EXP) ? CW_MIN_EXP : CW_EXP;

  logic [31:0] ecc_lo;
  logic [31:0] ecc_hi;
  logic [31:0] stat_word;

  assign ecc_lo    = {MAX_BAD, CW_FIELD, ECC_BITS};
  assign ecc_hi    = {16'h0000, ENDUR};
  assign stat_word = {1'b0, ready[sel_lun_r], 6'h00, 4'(sel_lun_r), 1'b0, out_mode_r,
                      mlun_r, rb_ready, 8'(pv_r), 8'(ready)};

  assign rd_mux = (ADR_I == A_CMD)    ? {24'h000000, last_op_r} :
                  (ADR_I == A_ROW)    ? row_r :
                  (ADR_I == A_COL)    ? col_r :
                  (ADR_I == A_STAT)   ? stat_word :
                  (ADR_I == A_DATA)   ? data_word :
                  (ADR_I == A_DEFECT) ? def_r :
                  (ADR_I == A_ECC_LO) ? ecc_lo :
                  (ADR_I == A_ECC_HI) ? ecc_hi : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_enh_cmd;
    cmd_go && op == OP_STAT_ENH;
  endsequence

  sequence s_data_read;
    rd_go && ADR_I == A_DATA && out_mode_r && pv_r[sel_lun_r];
  endsequence

  a_rb_any_busy: assert property (
    RB_OE_N_O == (st_r[0] == LUN_IDLE && st_r[NUM_LUNS-1] == LUN_IDLE))
    else $error("ready/busy disagrees with LUN states");

  a_multi_busy: assert property (
    (start_rd || start_pg) && !rb_ready |=> mlun_r && !RB_OE_N_O)
    else $error("second LUN start did not show busy");

  a_prog_clears: assert property (
    prog_clear && ready[0] && !rd_hit[0] && !pg_hit[0] |=> !pv_r[0])
    else $error("idle page register kept after unchained program");

  a_plane_keeps: assert property (
    cmd_go && op == OP_PROG && plane_r && st_r[0] == LUN_IDLE && pv_r[0] |=> pv_r[0])
    else $error("page register lost after chained program");

  a_read_parallel: assert property (
    rd_hit[0] && st_r[NUM_LUNS-1] == LUN_PROG |=> st_r[0] == LUN_READ)
    else $error("read refused during program on other LUN");

  a_enh_select: assert property (
    s_enh_cmd |=> sel_lun_r == $past(row_lun) && !out_mode_r ##1 &DQ_OE_N_O)
    else $error("enhanced status did not select or release drivers");

  a_one_driver: assert property (
    $countones(~DQ_OE_N_O) <= 1)
    else $error("more than one LUN drives data");

  a_page_kept: assert property (
    s_enh_cmd ##0 ready[0] |=> $stable(ld_row_r[0]) && $stable(pv_r[0]))
    else $error("enhanced status changed page register");

  a_mlun_clear: assert property (
    s_enh_cmd |=> !mlun_r)
    else $error("multi-LUN flag not cleared");

  a_marker_read: assert property (
    s_data_read ##0 def_hit |=> DAT_O[15:0] == MARK16)
    else $error("defect marker not returned");

  a_erased_read: assert property (
    s_data_read ##0 !def_hit |=> DAT_O[7:0] == ERASED8)
    else $error("good block did not read as ones");

  a_cw_min: assert property (
    ecc_lo[15:8] >= CW_MIN_EXP)
    else $error("codeword exponent below minimum");

  a_endur_min: assert property (
    ecc_hi[7:0] == 8'h00 || ecc_hi[7:0] % 8'h0A != 8'h00)
    else $error("endurance value not smallest");

  a_ack_pulse: assert property (
    ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

/* tb/mlfs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mlfs_host_model
  import mlfs_pkg::*;
#(
  parameter int PB = 2,
  parameter int BB = 4
) (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        rb_n_i,
  input  wire logic        rb_oe_n_i,
  output var logic         cyc_o,
  output var logic         stb_o,
  output var logic         we_o,
  output var logic [7:0]   adr_o,
  output var logic [3:0]   sel_o,
  output var logic [31:0]  dat_o,
  output logic             rb_wire_o,
  output var logic         hang_o
);
  // Open-drain line with pull-up
  assign rb_wire_o = rb_oe_n_i ? 1'b1 : rb_n_i;
  initial begin
    {cyc_o, stb_o, we_o, hang_o} = 4'h0;
    {adr_o, sel_o, dat_o} = 44'h0;
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'b11, we};
    {adr_o, sel_o, dat_o} <= {a, 4'hF, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
    if (n >= 16) hang_o <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_ready;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(A_STAT, q);
      n++;
    end while (q[16] !== 1'b1 && n < 64);
    if (n >= 64) hang_o <= 1'b1;
  endtask
  // Row: page low, block middle, LUN top
  function automatic logic [31:0] row(input int lun, input int blk, input int pg);
    return 32'((lun << (PB + BB)) | (blk << PB) | pg);
  endfunction
  // Read, select the LUN, enter output, then set column
  task automatic page_read(input int lun, input int blk, input int pg, input int col);
    wr(A_ROW, row(lun, blk, pg));
    wr(A_CMD, 32'(OP_READ_GO));
    wait_ready();
    wr(A_CMD, 32'(OP_STAT_ENH));
    wr(A_CMD, 32'(OP_READ));
    wr(A_COL, 32'(col));
  endtask
endmodule
`default_nettype wire

/* tb/test_multi_lun_flash_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module test_multi_lun_flash_sequencer;
  import mlfs_pkg::*;
  localparam int PE  = 16;
  localparam int PPB = 4;
  localparam int PB  = 2;
  localparam int BB  = 4;
  logic        clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        rb_n;
  logic        rb_oe_n;
  logic [1:0]  dq_oe_n;
  logic        rb_wire;
  logic        hang;
  logic [31:0] q;
  int          fail_count;
  int          comparisons;
  int          lun;
  int          blk;
  int          col;
  int          dlun;
  int          dblk;
  int          den;
  int          pgs[3] = '{0, 1, PPB - 1};

  mlfs_top #(.BLK_BITS(BB), .PAGE_BITS(PB), .COL_BITS(5), .PAGE_ELEMS(PE),
    .PAGES_PER_BLK(PPB), .READ_CYCLES(20), .PROG_CYCLES(30), .CW_EXP(8'h07)) dut_u (
    .CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .RB_N_O(rb_n), .RB_OE_N_O(rb_oe_n), .DQ_OE_N_O(dq_oe_n));
  mlfs_host_model #(.PB(PB), .BB(BB)) host_u (
    .clk_i(clk), .ack_i(ack), .dat_i(rdat), .rb_n_i(rb_n), .rb_oe_n_i(rb_oe_n), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .rb_wire_o(rb_wire), .hang_o(hang));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] exp_elem(input int l, input int b, input int p, input int c);
    if (den != 0 && c == PE && l == dlun && b == dblk && (p == 0 || p == PPB - 1)) return 32'(MARK8);
    return 32'(ERASED8);
  endfunction
  always @(posedge hang) begin
    fail_count++;
    finish_test();
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    q = $urandom(32'hEAB075B3);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    host_u.rd(A_STAT, q);
    chk("stat_reset", 32'h4001_0003, q & 32'h4007_0303);
    chk("dq_reset", 32'h3, {30'h0, dq_oe_n});
    host_u.rd(A_ECC_LO, q);
    chk("ecc_lo", 32'h0014_0904, q);
    host_u.rd(A_ECC_HI, q);
    chk("ecc_hi", 32'h0000_0501, q);
    host_u.rd(8'h20, q);
    chk("unmapped", 32'h0, q);
    // Bad block scan before any program
    for (int i = 0; i < 6; i++) begin
      dlun = $urandom % 2;
      dblk = $urandom % 16;
      den = (i < 5) ? 1 : 0;
      host_u.wr(A_DEFECT, 32'((den << 31) | (dlun << 16) | dblk));
      lun = (i == 4) ? 1 - dlun : dlun;
      blk = (i == 3) ? (dblk + 1) % 16 : dblk;
      for (int p = 0; p < 3; p++) begin
        for (int k = 0; k < 2; k++) begin
          col = k ? PE : int'($urandom % PE);
          host_u.page_read(lun, blk, pgs[p], col);
          host_u.rd(A_DATA, q);
          chk("data", exp_elem(lun, blk, pgs[p], col), q & 32'hFF);
          chk("dq_sel", 32'(~(2'b01 << lun) & 2'b11), {30'h0, dq_oe_n});
        end
      end
    end
    host_u.wr(A_DEFECT, 32'h0);
    // Program first, then read on the other LUN while it runs
    host_u.wr(A_ROW, host_u.row(1, 3, 0));
    host_u.wr(A_CMD, 32'(OP_PROG));
    host_u.wr(A_CMD, 32'(OP_PROG_GO));
    @(posedge clk);
    #1;
    chk("rb_prog", 32'h0, {31'h0, rb_wire});
    host_u.wr(A_ROW, host_u.row(0, 2, 0));
    host_u.wr(A_CMD, 32'(OP_READ_GO));
    host_u.rd(A_STAT, q);
    chk("stat_both", 32'h0002_0000, q & 32'h0003_0003);
    chk("rb_both", 32'h0, {31'h0, rb_wire});
    host_u.wait_ready();
    chk("rb_done", 32'h1, {31'h0, rb_wire});
    host_u.rd(A_STAT, q);
    chk("busy_keep", 32'h0002_0100, q & 32'h0002_0100);
    host_u.wr(A_ROW, host_u.row(0, 2, 0));
    host_u.wr(A_CMD, 32'(OP_STAT_ENH));
    host_u.wr(A_CMD, 32'(OP_READ));
    host_u.rd(A_STAT, q);
    chk("stat_enh", 32'h0005_0100, q & 32'h00F7_0100);
    chk("dq_enh", 32'h2, {30'h0, dq_oe_n});
    host_u.rd(A_DATA, q);
    chk("data_read", 32'(ERASED8), q);
    host_u.wr(A_CMD, 32'(OP_PLANE));
    host_u.wr(A_CMD, 32'(OP_PROG));
    host_u.rd(A_STAT, q);
    chk("chain_keep", 32'h0100, q & 32'h0100);
    host_u.wr(A_ROW, host_u.row(1, 3, 1));
    host_u.wr(A_CMD, 32'(OP_PROG_GO));
    host_u.wait_ready();
    host_u.wr(A_CMD, 32'(OP_PROG));
    host_u.rd(A_STAT, q);
    chk("idle_clear", 32'h0, q & 32'h0100);
    host_u.rd(A_DATA, q);
    chk("data_lost", 32'h0, q);
    host_u.wr(A_CMD, 32'(OP_STAT));
    host_u.rd(A_CMD, q);
    chk("last_op", 32'(OP_STAT), q);
    chk("dq_stat", 32'h3, {30'h0, dq_oe_n});
    host_u.rd(A_STAT, q);
    chk("stat_plain", 32'h0, q & 32'h0006_0000);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    host_u.rd(A_STAT, q);
    chk("stat_rerst", 32'h4001_0003, q & 32'h4007_0303);
    finish_test();
  end
endmodule
`default_nettype wire
